// ===== cog_pkg.sv
package cog_pkg;

   // Output count and widths.
   localparam int          NUM_OUT     = 8;
   localparam int          SYNC_W      = NUM_OUT + 1;
   localparam int          ADDR_W      = 12;
   localparam int          CNT_W       = 4;

   // Synchroniser reset value: enable pins idle high, power-good low.
   localparam logic [8:0]  SYNC_RESET  = 9'h0ff;
   localparam int          SYNC_PWR    = 8;

   // Clock rate and the output clock made from it.
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          OUT_DIV        = 2;
   localparam int          OUT_PERIOD_NS  = CLK_PERIOD_NS * OUT_DIV;

   // Latency figures in output clock periods.
   localparam int          ON_LAT_MIN      = 4;
   localparam int          LAT_MAX         = 12;
   localparam int          MIN_RUN         = 4;
   localparam int          ON_DELAY        = ON_LAT_MIN + 2;
   localparam int          OFF_DELAY       = MIN_RUN + 1;
   localparam logic [3:0]  ON_LAST         = 4'(ON_DELAY - 1);
   localparam logic [3:0]  OFF_LAST        = 4'(OFF_DELAY - 1);

   // Power-down qualification: rising output edges seen low.
   localparam logic [1:0]  PD_EDGES        = 2'h2;

   // Register map, byte addresses.
   localparam logic [11:0] REG_ENABLE      = 12'h000;
   localparam logic [11:0] REG_STATUS      = 12'h004;
   localparam logic [11:0] REG_IDENT       = 12'h008;
   localparam logic [7:0]  ENABLE_RESET    = 8'hff;

   // Status field positions.
   localparam int          STAT_RUN_LSB    = 0;
   localparam int          STAT_PIN_LSB    = 8;
   localparam int          STAT_PWR_BIT    = 16;
   localparam int          STAT_PDF_BIT    = 17;

   // Identification word; the value is arbitrary.
   localparam logic [31:0] IDENT_VALUE     = 32'h0000_c06a;

   // AXI responses.
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

// ===== cog_sync_if.sv
`timescale 1ns/100ps
`default_nettype none

// Carries raw asynchronous levels in and their settled copies out.
interface cog_sync_if;
   logic [8:0] raw;
   logic [8:0] stable;

   modport owner (output raw, input stable);
   modport sync  (input raw, output stable);
endinterface

`default_nettype wire

// ===== cog_sync.sv
`timescale 1ns/100ps
`default_nettype none

module cog_sync
(
   // Clock and reset.
   input  wire logic aclk,
   input  wire logic aresetn,
   // Levels to bring in.
   cog_sync_if.sync  port_sync
);

   typedef struct packed
   {
      logic [8:0] s1;
      logic [8:0] s2;
      logic [8:0] s3;
      logic [8:0] stable;
   } cog_sync_state_t;

   cog_sync_state_t r;
   cog_sync_state_t next_r;

   // Stage one feeds only stage two; a bit counts once stages two and
   // three agree, which filters a level caught mid-change.
   always_comb
   begin
      next_r    = r;
      next_r.s1 = port_sync.raw;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < cog_pkg::SYNC_W; i++)
      begin
         if (r.s2[i] == r.s3[i])
         begin
            next_r.stable[i] = r.s3[i];
         end
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r <= {4{cog_pkg::SYNC_RESET}};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign port_sync.stable = r.stable;

endmodule

`default_nettype wire

// ===== cog_gate_top.sv
// Overview of operation
// [R1] Software holds one enable bit per output, set over the register bus.
// [R2] Each output has its own active-low enable pin, taken at any time.
// [R3] Software enable bits are active high and reset to enabled.
// [R4] A disabled output drives both legs of its pair low.
// [R5] An output runs only with its enable bit at 1 and its pin at 0.
// [R6] A re-enabled output restarts without glitches or runt pulses.
// [R7] After the pin falls the output starts within 4 to 12 output periods.
// [R8] When the pin rises the output stops cleanly with no cut pulse.
// [R9] After the pin rises at least four whole cycles still come out.
// [R10] After the pin rises the output is stopped within 12 periods.
// [R11] While power-good is low every output is held low on both legs; here only once two rising output edges have seen it low.
// [R12] Power-down seen on two rising output edges stops all at the fall.
// [R13] Pins are synchronised and the gate only changes in the low phase.
`timescale 1ns/100ps
`default_nettype none

module cog_gate_top
(
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address channel.
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // Write data channel.
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // Write response channel.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // Read address channel.
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // Read data channel.
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Asynchronous control pins.
   input  wire logic [7:0]  out_enable_n,
   input  wire logic        power_good_down_n,
   // Differential clock outputs.
   output logic [7:0]       diff_clock_out_p,
   output logic [7:0]       diff_clock_out_n
);

   // Everything the block remembers outside the synchroniser lives in one record: the divided
   // output clock, one gate and one dwell counter per pair, the
   // power-down edge count, the registered pair legs, the software
   // enables and the bus slave's held halves and answers.
   typedef struct packed
   {
      // Output clock generation and gating.
      logic             phase;
      logic [7:0]       gate;
      logic [7:0][3:0]  cnt;
      logic [1:0]       pd_cnt;
      logic [7:0]       out_p;
      logic [7:0]       out_n;
      // Software enables.
      logic [7:0]       sw_en;
      // Write side of the bus.
      logic             aw_got;
      logic [11:0]      aw_addr;
      logic             w_got;
      logic [31:0]      w_data;
      logic [3:0]       w_strb;
      logic             bvalid;
      logic [1:0]       bresp;
      // Read side of the bus.
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
   } cog_gate_state_t;

   // Reset value: every pair stopped low/low and every software enable
   // set, so the pins alone decide once the synchroniser has settled.
   localparam cog_gate_state_t STATE_RESET = '{
      phase:   1'b0,
      gate:    8'h00,
      cnt:     '0,
      pd_cnt:  2'h0,
      out_p:   8'h00,
      out_n:   8'h00,
      sw_en:   cog_pkg::ENABLE_RESET,
      aw_got:  1'b0,
      aw_addr: 12'h000,
      w_got:   1'b0,
      w_data:  32'h0000_0000,
      w_strb:  4'h0,
      bvalid:  1'b0,
      bresp:   cog_pkg::RESP_OKAY,
      rvalid:  1'b0,
      rdata:   32'h0000_0000,
      rresp:   cog_pkg::RESP_OKAY
   };

   cog_gate_state_t r;
   cog_gate_state_t next_r;

   cog_sync_if sync_bus ();

   logic [7:0] pin_n;
   logic       pwr_ok;
   logic       pd_force;

   // Word-aligned register decode shared by reads and writes. Low
   // address bits are ignored, so any byte inside a word selects it.
   function automatic logic is_mapped(input logic [11:0] addr);
      logic [11:0] word;
      word = {addr[11:2], 2'b00};
      return (word == cog_pkg::REG_ENABLE) ||
             (word == cog_pkg::REG_STATUS) ||
             (word == cog_pkg::REG_IDENT);
   endfunction

   // Word select of an address.
   function automatic logic [11:0] word_of(input logic [11:0] addr);
      return {addr[11:2], 2'b00};
   endfunction

   // Enable pins and power-good cross in through four flops. The
   // synchroniser resets to pins high and power low, so no pair can
   // start before real pin levels have been seen.
   assign sync_bus.raw = {power_good_down_n, out_enable_n}; // [R2] [R13]

   cog_sync u_sync
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .port_sync (sync_bus)
   );

   // Settled pin levels in the bus clock domain. Only these copies
   // are read below; the raw pins never reach the gate logic.
   assign pin_n    = sync_bus.stable[7:0];
   assign pwr_ok   = sync_bus.stable[cog_pkg::SYNC_PWR];
   assign pd_force = (r.pd_cnt == cog_pkg::PD_EDGES);

   // Next-state logic for the clock gates and the bus slave.
   // Start budget: three or four cycles through the synchroniser, then
   // ON_DELAY low-phase boundaries, about eight output periods in all,
   // inside the four to twelve that the pins allow.
   // Stop budget: the same crossing, then OFF_DELAY boundaries during
   // which the running clock keeps going, so at least four whole cycles
   // leave the pair and it is parked within about seven periods.
   always_comb
   begin
      logic       want;
      logic [3:0] last;
      logic [31:0] rd;
      logic       aw_take;
      logic       w_take;
      want    = 1'b0;
      last    = 4'h0;
      rd      = 32'h0000_0000;
      aw_take = 1'b0;
      w_take  = 1'b0;
      next_r  = r;

      // The output clock is the bus clock divided by two.
      next_r.phase = ~r.phase;

      // Count rising output edges at which power-down is seen low. The
      // count saturates at two, and a rising-edge sample with power good
      // clears it, so a dip shorter than two edges never forces a stop.
      if (!r.phase)
      begin
         if (!pwr_ok)
         begin
            if (r.pd_cnt != cog_pkg::PD_EDGES)
            begin
               next_r.pd_cnt = r.pd_cnt + 2'h1; // [R12]
            end
         end
         else
         begin
            next_r.pd_cnt = 2'h0;
         end
      end

      // Gates move only on the cycle before the low half begins.
      // A forced power-down beats the minimum run; otherwise a change of
      // want must hold for the whole dwell count, and one that reverts
      // early starts the count again.
      for (int i = 0; i < cog_pkg::NUM_OUT; i++)
      begin
         want = r.sw_en[i] & ~pin_n[i] & pwr_ok; // [R5] [R11]
         last = want ? cog_pkg::ON_LAST : cog_pkg::OFF_LAST;
         if (r.phase)
         begin
            if (pd_force)
            begin
               next_r.gate[i] = 1'b0; // [R12] [R11]
               next_r.cnt[i]  = 4'h0;
            end
            else if (want != r.gate[i])
            begin
               // Starting waits a few periods; stopping keeps the
               // running clock going for the full minimum.
               if (r.cnt[i] == last)
               begin
                  next_r.gate[i] = want; // [R7] [R9] [R10] [R13]
                  next_r.cnt[i]  = 4'h0;
               end
               else
               begin
                  next_r.cnt[i] = r.cnt[i] + 4'h1;
               end
            end
            else
            begin
               next_r.cnt[i] = 4'h0;
            end
         end
      end

      // Pair legs follow the gate, so a stopped pair sits low/low and a
      // restart always begins with a whole low half on the p leg.
      for (int i = 0; i < cog_pkg::NUM_OUT; i++)
      begin
         next_r.out_p[i] = next_r.gate[i] & next_r.phase;  // [R4] [R6]
         next_r.out_n[i] = next_r.gate[i] & ~next_r.phase; // [R4] [R8]
      end

      // Write address and data are taken in either order. Each ready
      // stays low while its own half is held, and both while the response
      // waits, so a second write can never overtake the first.
      aw_take = s_axi_awvalid & ~r.aw_got & ~r.bvalid;
      w_take  = s_axi_wvalid & ~r.w_got & ~r.bvalid;
      if (aw_take)
      begin
         next_r.aw_got  = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (w_take)
      begin
         next_r.w_got  = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end

      // Both halves present: perform the write and answer.
      if (r.aw_got && r.w_got)
      begin
         next_r.aw_got = 1'b0;
         next_r.w_got  = 1'b0;
         next_r.bvalid = 1'b1;
         if (!is_mapped(r.aw_addr))
         begin
            next_r.bresp = cog_pkg::RESP_SLVERR;
         end
         else
         begin
            next_r.bresp = cog_pkg::RESP_OKAY;
            if (word_of(r.aw_addr) == cog_pkg::REG_ENABLE && r.w_strb[0])
            begin
               next_r.sw_en = r.w_data[7:0]; // [R1] [R3]
            end
         end
      end
      else if (r.bvalid && s_axi_bready)
      begin
         next_r.bvalid = 1'b0;
      end

      // Read data for the addressed word.
      unique case (word_of(s_axi_araddr))
         cog_pkg::REG_ENABLE:
         begin
            rd[7:0] = r.sw_en;
         end
         cog_pkg::REG_STATUS:
         begin
            rd[cog_pkg::STAT_RUN_LSB +: 8] = r.gate;
            rd[cog_pkg::STAT_PIN_LSB +: 8] = pin_n;
            rd[cog_pkg::STAT_PWR_BIT]      = pwr_ok;
            rd[cog_pkg::STAT_PDF_BIT]      = pd_force;
         end
         cog_pkg::REG_IDENT:
         begin
            rd = cog_pkg::IDENT_VALUE;
         end
         default:
         begin
            rd = 32'h0000_0000;
         end
      endcase

      // One read at a time; the answer stands until rready. The word is
      // captured when the address is taken, so a later change of the
      // pins does not alter data already on offer.
      if (s_axi_arvalid && !r.rvalid)
      begin
         next_r.rvalid = 1'b1;
         next_r.rdata  = rd;
         next_r.rresp  = is_mapped(s_axi_araddr) ? cog_pkg::RESP_OKAY
                                                 : cog_pkg::RESP_SLVERR;
      end
      else if (r.rvalid && s_axi_rready)
      begin
         next_r.rvalid = 1'b0;
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r <= STATE_RESET;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Handshake outputs.
   assign s_axi_awready = ~r.aw_got & ~r.bvalid;
   assign s_axi_wready  = ~r.w_got & ~r.bvalid;
   assign s_axi_bvalid  = r.bvalid;
   assign s_axi_bresp   = r.bresp;
   assign s_axi_arready = ~r.rvalid;
   assign s_axi_rvalid  = r.rvalid;
   assign s_axi_rdata   = r.rdata;
   assign s_axi_rresp   = r.rresp;

   // Clock outputs straight from flops, so no gate logic sits between
   // the register and the pins and no glitch can reach a pair.
   assign diff_clock_out_p = r.out_p;
   assign diff_clock_out_n = r.out_n;

endmodule

`default_nettype wire

// ===== cog_gate_checker.sv
`timescale 1ns/100ps
`default_nettype none

module cog_gate_checker
(
   // Clock and reset.
   input wire logic       aclk,
   input wire logic       aresetn,
   // Bus handshakes.
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   // Pins and outputs.
   input wire logic [7:0] out_enable_n,
   input wire logic       power_good_down_n,
   input wire logic [7:0] diff_clock_out_p,
   input wire logic [7:0] diff_clock_out_n
);
   logic [4:0] on_cnt;
   logic [4:0] off_cnt;
   logic       run0;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Output 0 is running whenever either leg is high.
   assign run0 = diff_clock_out_p[0] | diff_clock_out_n[0];

   // Cycles that pin 0 has stood low, or high, with power good.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || out_enable_n[0] || !power_good_down_n)
         on_cnt <= 5'h00;
      else if (on_cnt != 5'h1f)
         on_cnt <= on_cnt + 5'h01;
      if (!aresetn || !out_enable_n[0] || !power_good_down_n)
         off_cnt <= 5'h00;
      else if (off_cnt != 5'h1f)
         off_cnt <= off_cnt + 5'h01;
   end

   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_pin_on;
      $fell(out_enable_n[0]) && !run0;
   endsequence
   sequence s_pin_off;
      $rose(out_enable_n[0]) && power_good_down_n && run0;
   endsequence

   AST_PAIR: assert property (
      (diff_clock_out_p & diff_clock_out_n) == 8'h00)
      else $error("Both legs of a pair are high.");
   AST_NORUNT: assert property (
      ((diff_clock_out_p & $past(diff_clock_out_p))
      | (diff_clock_out_n & $past(diff_clock_out_n))) == 8'h00)
      else $error("A leg stayed high longer than one half period.");
   AST_ON_MIN: assert property (s_pin_on |-> (!run0) [*8])
      else $error("Output started sooner than four periods.");
   AST_ON_MAX: assert property (on_cnt == 5'h18 |-> run0)
      else $error("Output not running twelve periods after enable.");
   AST_OFF_MIN: assert property (s_pin_off |-> run0 [*8])
      else $error("Output stopped before four whole cycles.");
   AST_OFF_MAX: assert property (off_cnt == 5'h18 |-> !run0)
      else $error("Output still running twelve periods after disable.");
   AST_PWR: assert property ((!power_good_down_n) [*8] |-> ##4
      (diff_clock_out_p | diff_clock_out_n) == 8'h00)
      else $error("Outputs not held low during power down.");
   AST_WR: assert property (s_wr |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("Write response not given two cycles after taking.");
   AST_RD: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read data not given one cycle after taking.");
endmodule

bind cog_gate_top cog_gate_checker u_cog_gate_checker
(
   .aclk              (aclk),
   .aresetn           (aresetn),
   .s_axi_awvalid     (s_axi_awvalid),
   .s_axi_awready     (s_axi_awready),
   .s_axi_wvalid      (s_axi_wvalid),
   .s_axi_wready      (s_axi_wready),
   .s_axi_bvalid      (s_axi_bvalid),
   .s_axi_arvalid     (s_axi_arvalid),
   .s_axi_arready     (s_axi_arready),
   .s_axi_rvalid      (s_axi_rvalid),
   .out_enable_n      (out_enable_n),
   .power_good_down_n (power_good_down_n),
   .diff_clock_out_p  (diff_clock_out_p),
   .diff_clock_out_n  (diff_clock_out_n)
);

`default_nettype wire

// ===== cog_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

module cog_pin_model
(
   // Wanted state from the bench.
   input  wire logic [7:0] want_on,
   input  wire logic       pwr_on,
   // Pins into the device.
   output logic [7:0]      out_enable_n,
   output logic            power_good_down_n
);
   // Pins move a few ns after a request, unrelated to any clock edge.
   assign #3 out_enable_n      = ~want_on;
   assign #3 power_good_down_n = pwr_on;
endmodule

`default_nettype wire

// ===== cog_gate_top_bench.sv
`timescale 1ns/100ps
`default_nettype none

module cog_gate_top_bench;
   // Bench drives.
   logic        aclk    = 1'h0;
   logic        aresetn = 1'h0;
   logic [11:0] awaddr  = 12'h000;
   logic [11:0] araddr  = 12'h000;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  wstrb   = 4'hf;
   logic        awvalid = 1'h0;
   logic        wvalid  = 1'h0;
   logic        bready  = 1'h0;
   logic        arvalid = 1'h0;
   logic        rready  = 1'h0;
   logic [7:0]  want_on = 8'hff;
   logic        pwr_on  = 1'h1;
   // Design answers.
   logic        awready, wready, bvalid, arready, rvalid, pg_n;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, rd_val;
   logic [7:0]  oe_n, clk_p, clk_n;
   int          err_total   = 0;
   int          check_count = 0;

   // Free-running 100 MHz clock.
   always #5 aclk = ~aclk;

   cog_pin_model u_cog_pin_model
   (
      .want_on           (want_on),
      .pwr_on            (pwr_on),
      .out_enable_n      (oe_n),
      .power_good_down_n (pg_n)
   );

   cog_gate_top u_cog_gate_top
   (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .s_axi_awaddr      (awaddr),
      .s_axi_awvalid     (awvalid),
      .s_axi_awready     (awready),
      .s_axi_wdata       (wdata),
      .s_axi_wstrb       (wstrb),
      .s_axi_wvalid      (wvalid),
      .s_axi_wready      (wready),
      .s_axi_bresp       (bresp),
      .s_axi_bvalid      (bvalid),
      .s_axi_bready      (bready),
      .s_axi_araddr      (araddr),
      .s_axi_arvalid     (arvalid),
      .s_axi_arready     (arready),
      .s_axi_rdata       (rdata),
      .s_axi_rresp       (rresp),
      .s_axi_rvalid      (rvalid),
      .s_axi_rready      (rready),
      .out_enable_n      (oe_n),
      .power_good_down_n (pg_n),
      .diff_clock_out_p  (clk_p),
      .diff_clock_out_n  (clk_n)
   );

   // Compares one value and counts it.
   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask

   // Writes one word; both halves offered together.
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end
      while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk("bresp", 32'h0, {30'h0, bresp});
   endtask

   // Reads one word into rd_val and resp.
   task automatic axi_rd(input logic [11:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end
      while (rvalid !== 1'h1);
      rd_val = rdata;
      resp   = rresp;
      rready <= 1'h0;
      chk("rvalid", 32'h1, {31'h0, rvalid});
   endtask

   // Running pairs must be complementary and toggle; others Low/Low.
   task automatic run_chk(input logic [7:0] mask);
      logic [7:0] prev;
      @(negedge aclk);
      prev = clk_p;
      chk("pairs", {24'h0, mask},
          {16'h0, clk_p & clk_n, clk_p ^ clk_n});
      @(negedge aclk);
      chk("toggle", {24'h0, mask}, {24'h0, clk_p ^ prev});
   endtask

   // Prints the verdict and ends the run.
   task automatic tally_and_finish();
      if (err_total == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Main sequence of tests.
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(cog_pkg::REG_ENABLE);
      chk("enable_reset", 32'h0000_00ff, rd_val);
      chk("rresp", {30'h0, cog_pkg::RESP_OKAY}, {30'h0, resp});
      axi_rd(cog_pkg::REG_IDENT);
      chk("ident", cog_pkg::IDENT_VALUE, rd_val);
      axi_rd(12'h00c);
      chk("unmapped", {30'h0, cog_pkg::RESP_SLVERR}, {30'h0, resp});
      repeat (40) @(posedge aclk);
      run_chk(8'hff);
      axi_wr(cog_pkg::REG_ENABLE, 32'h0000_00fd);
      repeat (30) @(posedge aclk);
      run_chk(8'hfd);
      axi_rd(cog_pkg::REG_STATUS);
      chk("status_run", (32'h1 << cog_pkg::STAT_PWR_BIT) | 32'h0000_00fd,
          rd_val);
      wstrb <= 4'h0;
      axi_wr(cog_pkg::REG_ENABLE, 32'h0000_0000);
      wstrb <= 4'hf;
      axi_rd(cog_pkg::REG_ENABLE);
      chk("enable_kept", 32'h0000_00fd, rd_val);
      want_on <= 8'hfe;
      repeat (30) @(posedge aclk);
      run_chk(8'hfc);
      want_on <= 8'hff;
      repeat (30) @(posedge aclk);
      run_chk(8'hfd);
      axi_wr(cog_pkg::REG_ENABLE, 32'h0000_00ff);
      pwr_on <= 1'h0;
      repeat (20) @(posedge aclk);
      run_chk(8'h00);
      axi_rd(cog_pkg::REG_STATUS);
      chk("status_pd", 32'h1 << cog_pkg::STAT_PDF_BIT, rd_val);
      pwr_on <= 1'h1;
      repeat (40) @(posedge aclk);
      run_chk(8'hff);
      tally_and_finish();
   end

   // Cuts the run short if the tests hang.
   initial
   begin
      #100000;
      err_total++;
      tally_and_finish();
   end
endmodule

`default_nettype wire
